/* ajds_jack_model.sv */
`timescale 1ns/1ps
module ajds_jack_model (
  input  wire logic                i_lclk,       // jack event clock
  input  wire logic                i_plug,       // accessory in
  input  wire ajds_pkg::ajds_acc_t i_kind,       // accessory type
  output logic                     o_sense_n,    // sense pin
  output logic                     o_mic_sleeve, // mic load on sleeve
  output logic                     o_mic_ring_two_contact   // mic load on ring two
);
  logic sense_q = 1'b1;
  logic tog_q = 1'b0;
  always @(posedge i_lclk) begin
    sense_q <= !i_plug;
    tog_q <= !tog_q;
  end
  assign o_sense_n = sense_q;
  // open jack: comparators give no settled level
  assign o_mic_sleeve = sense_q ? tog_q : (i_kind == ajds_pkg::AJDS_4STD);
  assign o_mic_ring_two_contact = sense_q ? !tog_q : (i_kind == ajds_pkg::AJDS_4ALT);
endmodule // ajds_jack_model

/* ajds_pkg.sv */
package ajds_pkg;
  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam int unsigned INS_DEB_MS      = 90;
  localparam int unsigned REM_DEB_MS      = 50;
  localparam int unsigned INS_DEB_CYC     = (INS_DEB_MS * (CLK_HZ / 1000));
  localparam int unsigned REM_DEB_CYC     = (REM_DEB_MS * (CLK_HZ / 1000));
  localparam int unsigned CNT_W           = 24;
  localparam int unsigned DET_WAIT_US     = 10;
  localparam int unsigned DET_WAIT_CYC    = (DET_WAIT_US * (CLK_HZ / 1_000_000));
  localparam logic [7:0]  SW_RST          = 8'h00;

  typedef enum logic [1:0] {AJDS_NONE, AJDS_3POLE, AJDS_4STD, AJDS_4ALT} ajds_acc_t;

  // switch bundle: bit order is the field order below
  typedef struct packed {
    logic bias_to_sleeve;   // mic_supply_line -> sleeve
    logic bias_to_ring_two_contact;    // mic_supply_line -> ring_two_contact
    logic mic_to_sleeve;    // mic_signal_line -> sleeve
    logic mic_to_ring_two_contact;     // mic_signal_line -> ring_two_contact
    logic gnd_to_sleeve;    // analog_ground_line -> sleeve
    logic gnd_to_ring_two_contact;     // analog_ground_line -> ring_two_contact
    logic fm_path;          // ground path passes fm
    logic dfet_on;          // depletion grounding active
  } ajds_sw_t;

  typedef struct packed {
    logic ins_deb;
    logic rem_deb;
    logic det_trig;
    logic ovr_en;
    logic fm_en;
  } ajds_cfg_t;
endpackage

/* ajds_seq.sv */
`timescale 1ns/1ps
// What this block does
// - stable low sense pin starts the 90 ms insertion debounce.
// - sense pin high during debounce restarts the count.
// - detection begins as soon as insertion debounce ends.
// - switches route first, then alert low; four-contact also mic found low.
// - host reads the interrupt register; that read releases the alert.
// - removal changes switches at once, alerts, releases mic found.
// - after removal wait 50 ms, then sleep unless override enabled.
// - removal aborts insertion, detection and key handling.
// - removal during insertion debounce returns to waiting for stable low.
// - removal after detection began goes straight to removal handling.
// - under override, removal leaves the switches unchanged.
// - detection starts from falling sense pin or software command.
// - mic supply stays off the jack before insertion is detected.
// - detected mic connects mic line to the contact carrying it.
// - analog ground goes to the contact found as headset ground.
// - fm ground path enabled only when the fm bit is one.
// - low-power sleep while no accessory is inserted.
// - host controls every switch and the insertion debounce length.
// - override never changes switches during detection; pending values wait.
module ajds_seq #(
  parameter int unsigned INS_CYC = ajds_pkg::INS_DEB_CYC,  // insertion debounce
  parameter int unsigned REM_CYC = ajds_pkg::REM_DEB_CYC,  // removal debounce
  parameter int unsigned DET_CYC = ajds_pkg::DET_WAIT_CYC  // detection settle
) (
  input  wire logic               i_mclk,       // 10 MHz clock
  input  wire logic               i_nrst,       // async reset, active low
  input  wire logic               i_sense_n,    // insertion-sense pin, low = inserted
  input  wire logic               i_mic_sleeve, // comparator: mic load on sleeve
  input  wire logic               i_mic_ring_two_contact,  // comparator: mic load on ring two
  input  wire logic [23:0]        i_ins_cyc,    // host insertion debounce, 0 = default
  input  wire logic               i_ovr_en,     // manual switch override
  input  wire ajds_pkg::ajds_sw_t i_ovr_sw,     // host switch settings
  input  wire logic               i_fm_en,      // fm support bit
  input  wire logic               i_det_cmd,    // software detection pulse
  input  wire logic               i_int_rd,     // interrupt register read pulse
  input  wire logic               i_key_en,     // host key detection request
  output ajds_pkg::ajds_sw_t      o_sw,         // switch controls
  output ajds_pkg::ajds_acc_t     o_acc,        // detected accessory type
  output logic                    o_alert_oe,   // alert pin driven low
  output logic                    o_alert_o,    // alert pin output level
  output logic                    o_mic_found_n_oe, // mic found pin driven low
  output logic                    o_mic_found_n_o,  // mic found pin output level
  output logic                    o_key_act,    // key detection active
  output logic                    o_sleep,      // low-power sleep
  output logic                    o_busy        // detection running
);
  typedef enum logic [2:0] {
    AJDS_SLEEP, AJDS_DEB, AJDS_DET, AJDS_ROUTE, AJDS_ACTIVE, AJDS_REM
  } ajds_st_t;

  typedef struct packed {
    ajds_st_t            st;
    logic                sense_d1;
    logic                cmd_pend;
    ajds_pkg::ajds_acc_t acc;
    ajds_pkg::ajds_sw_t  auto_sw;
    ajds_pkg::ajds_sw_t  sw;
    logic                alert;
    logic                mic;
    logic                key;
    logic                sleep;
    logic                busy;
  } ajds_state_t;

  function automatic ajds_pkg::ajds_sw_t route(input ajds_pkg::ajds_acc_t a,
                                               input logic fm);
    ajds_pkg::ajds_sw_t s;
    s = ajds_pkg::SW_RST;
    case (a)
      ajds_pkg::AJDS_4STD: begin
        s.bias_to_sleeve = 1'b1;
        s.mic_to_sleeve  = 1'b1;
        s.gnd_to_ring_two_contact   = 1'b1;
      end
      ajds_pkg::AJDS_4ALT: begin
        s.bias_to_ring_two_contact = 1'b1;
        s.mic_to_ring_two_contact  = 1'b1;
        s.gnd_to_sleeve = 1'b1;
      end
      ajds_pkg::AJDS_3POLE: begin
        s.gnd_to_sleeve = 1'b1;
        s.gnd_to_ring_two_contact  = 1'b1;
      end
      default: s.dfet_on = 1'b1;
    endcase
    s.fm_path = fm && (a != ajds_pkg::AJDS_NONE);
    return s;
  endfunction

  ajds_state_t q, d;
  logic        sense_s;
  logic        ins_done, rem_done, det_done;
  logic [23:0] ins_lim;

  ajds_sync u_sync (
    .i_mclk  (i_mclk),
    .i_nrst  (i_nrst),
    .i_async (i_sense_n),
    .o_sync  (sense_s)
  );

  assign ins_lim = (i_ins_cyc != 24'h000000) ? i_ins_cyc : 24'(INS_CYC);

  ajds_timer #(.W(24)) u_ins (
    .i_mclk  (i_mclk),
    .i_nrst  (i_nrst),
    .i_clr   (sense_s),
    .i_run   (q.st == AJDS_DEB),
    .i_limit (ins_lim),
    .o_done  (ins_done)
  );

  ajds_timer #(.W(24)) u_rem (
    .i_mclk  (i_mclk),
    .i_nrst  (i_nrst),
    .i_clr   (!sense_s),
    .i_run   (q.st == AJDS_REM),
    .i_limit (24'(REM_CYC)),
    .o_done  (rem_done)
  );

  ajds_timer #(.W(24)) u_det (
    .i_mclk  (i_mclk),
    .i_nrst  (i_nrst),
    .i_clr   (1'b0),
    .i_run   (q.st == AJDS_DET),
    .i_limit (24'(DET_CYC)),
    .o_done  (det_done)
  );

  always_comb begin
    d          = q;
    d.sense_d1 = sense_s;
    if (i_det_cmd) begin
      d.cmd_pend = 1'b1;
    end
    if (i_int_rd) begin
      d.alert = 1'b0;
    end
    case (q.st)
      AJDS_SLEEP: begin
        if (q.sense_d1 && !sense_s) begin
          d.st = AJDS_DEB;
        end else if (q.cmd_pend || i_det_cmd) begin
          d.cmd_pend = 1'b0;
          d.st       = AJDS_DET;
        end
      end
      AJDS_DEB: begin
        if (sense_s) begin
          d.st = AJDS_SLEEP;
        end else if (ins_done) begin
          d.st = AJDS_DET;
        end
      end
      AJDS_DET: begin
        if (det_done) begin
          // a command landing on the last detection cycle is kept
          d.cmd_pend = i_det_cmd;
          if (i_mic_sleeve) begin
            d.acc = ajds_pkg::AJDS_4STD;
          end else if (i_mic_ring_two_contact) begin
            d.acc = ajds_pkg::AJDS_4ALT;
          end else begin
            d.acc = ajds_pkg::AJDS_3POLE;
          end
          d.st = AJDS_ROUTE;
        end
      end
      AJDS_ROUTE: begin
        d.alert = 1'b1;
        d.mic   = (q.acc == ajds_pkg::AJDS_4STD) || (q.acc == ajds_pkg::AJDS_4ALT);
        d.st    = AJDS_ACTIVE;
      end
      AJDS_ACTIVE: begin
        if (q.cmd_pend) begin
          d.cmd_pend = 1'b0;
          d.st       = AJDS_DET;
        end
      end
      AJDS_REM: begin
        if (!sense_s) begin
          d.st = AJDS_DEB;
        end else if (rem_done) begin
          d.st = AJDS_SLEEP;
        end
      end
      default: d.st = AJDS_SLEEP;
    endcase
    if (sense_s && (q.st == AJDS_DET || q.st == AJDS_ROUTE || q.st == AJDS_ACTIVE)) begin
      d.st  = AJDS_REM;
      d.acc = ajds_pkg::AJDS_NONE;
      d.alert = 1'b1;
      d.mic   = 1'b0;
    end
    // automatic routing
    // routes follow the new type so they settle a cycle before the alert
    d.auto_sw = (d.st == AJDS_ROUTE || d.st == AJDS_ACTIVE) ? route(d.acc, i_fm_en)
                                                          : route(ajds_pkg::AJDS_NONE, 1'b0);
    if (d.st == AJDS_DET || d.st == AJDS_DEB) begin
      d.sw = q.sw;
    end else if (i_ovr_en) begin
      d.sw = i_ovr_sw;
    end else if (d.st == AJDS_REM && q.st != AJDS_REM) begin
      d.sw = d.auto_sw;
    end else begin
      d.sw = d.auto_sw;
    end
    d.key   = i_key_en && q.mic && (d.st == AJDS_ACTIVE);
    d.sleep = (d.st == AJDS_SLEEP) && !i_ovr_en;
    d.busy  = (d.st == AJDS_DET) || (d.st == AJDS_ROUTE);
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      q          <= '0;
      q.st       <= AJDS_SLEEP;
      q.sense_d1 <= 1'b1;
      q.sw       <= ajds_pkg::ajds_sw_t'(8'h01);
      q.auto_sw  <= ajds_pkg::ajds_sw_t'(8'h01);
      q.sleep    <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign o_alert_oe       = q.alert;
  assign o_alert_o        = 1'b0;
  assign o_mic_found_n_oe = q.mic;
  assign o_mic_found_n_o  = 1'b0;
  assign o_sw             = q.sw;
  assign o_acc            = q.acc;
  assign o_key_act        = q.key;
  assign o_sleep          = q.sleep;
  assign o_busy           = q.busy;
endmodule // ajds_seq

/* ajds_seq_props.sv */
`timescale 1ns/1ps
module ajds_seq_props #(
  parameter int unsigned INS_CYC = 50,
  parameter int unsigned REM_CYC = 30,
  parameter int unsigned DET_CYC = 5
) (
  input wire logic                i_mclk,           // clock
  input wire logic                i_nrst,           // reset
  input wire logic                i_sense_n,        // sense pin
  input wire logic [23:0]         i_ins_cyc,        // debounce
  input wire logic                i_ovr_en,         // override
  input wire logic                i_fm_en,          // fm bit
  input wire logic                i_int_rd,         // read pulse
  input wire ajds_pkg::ajds_sw_t  o_sw,             // switches
  input wire ajds_pkg::ajds_acc_t o_acc,            // type
  input wire logic                o_alert_oe,       // alert
  input wire logic                o_alert_o,        // alert level
  input wire logic                o_mic_found_n_oe, // mic found
  input wire logic                o_mic_found_n_o,  // mic level
  input wire logic                o_key_act,        // key active
  input wire logic                o_sleep,          // sleep
  input wire logic                o_busy            // detecting
);
  logic [15:0] run_q;
  logic        sen_q;
  logic [23:0] lim;
  logic        four;
  logic        man;
  assign lim = (i_ins_cyc == 24'h0) ? 24'(INS_CYC) : i_ins_cyc;
  assign four = o_acc[1];
  // cycles since the sense pin last changed
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      run_q <= 16'h0;
      sen_q <= 1'b1;
    end else begin
      sen_q <= i_sense_n;
      run_q <= (i_sense_n != sen_q) ? 16'h0 : run_q + 16'((&run_q) ? 0 : 1);
    end
  end
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);
  always_ff @(posedge i_mclk) man <= i_ovr_en;
  sequence s_remove;
    $rose(i_sense_n) && (o_acc != ajds_pkg::AJDS_NONE);
  endsequence
  sequence s_cleared;
    (o_acc == ajds_pkg::AJDS_NONE) && o_alert_oe && !o_mic_found_n_oe && !o_key_act;
  endsequence
  chk_od_low:
    assert property (!o_alert_o && !o_mic_found_n_o) else $error("open-drain level high");
  chk_mic_four:
    assert property (o_mic_found_n_oe |-> four) else $error("mic found without mic");
  chk_remove_clear:
    assert property (s_remove |-> ##[1:5] s_cleared) else $error("removal not handled");
  chk_bias_sleep:
    assert property (o_sleep |-> !o_sw.bias_to_sleeve && !o_sw.bias_to_ring_two_contact)
      else $error("bias on in sleep");
  chk_std_route:
    assert property (o_mic_found_n_oe && o_acc == ajds_pkg::AJDS_4STD && !i_ovr_en && !man
      |-> o_sw.mic_to_sleeve && o_sw.gnd_to_ring_two_contact && !o_sw.gnd_to_sleeve) else $error("std route");
  chk_alt_route:
    assert property (o_mic_found_n_oe && o_acc == ajds_pkg::AJDS_4ALT && !i_ovr_en && !man
      |-> o_sw.mic_to_ring_two_contact && o_sw.gnd_to_sleeve && !o_sw.gnd_to_ring_two_contact) else $error("alt route");
  chk_route_first:
    assert property ($rose(o_alert_oe) && o_acc != ajds_pkg::AJDS_NONE && !i_ovr_en && !man
      |-> $past(o_sw[7:2]) == o_sw[7:2] && o_sw[7:2] != 6'h00)
      else $error("alert before routing");
  chk_fm_gate:
    assert property (!i_ovr_en && !man && !$past(i_fm_en) |-> !o_sw.fm_path)
      else $error("fm path without fm bit");
  chk_read_clear:
    assert property (i_int_rd && !o_busy && $stable(o_acc) |-> ##[1:2] !o_alert_oe)
      else $error("alert kept after read");
  chk_key_gate:
    assert property (o_key_act |-> four) else $error("key active without headset");
  chk_deb_len:
    assert property ($rose(o_busy) |-> 32'(run_q) + 32'd2 >= 32'(lim))
      else $error("detection before debounce");
  chk_rem_sleep:
    assert property (i_sense_n && run_q == 16'(REM_CYC + 10) && !i_ovr_en && !man |-> o_sleep)
      else $error("no sleep after removal");
endmodule // ajds_seq_props
bind ajds_seq ajds_seq_props #(.INS_CYC(INS_CYC), .REM_CYC(REM_CYC), .DET_CYC(DET_CYC))
  i_ajds_seq_props (.i_mclk, .i_nrst, .i_sense_n, .i_ins_cyc, .i_ovr_en, .i_fm_en, .i_int_rd,
  .o_sw, .o_acc, .o_alert_oe, .o_alert_o, .o_mic_found_n_oe, .o_mic_found_n_o, .o_key_act,
  .o_sleep, .o_busy);

/* ajds_sync.sv */
`timescale 1ns/1ps
module ajds_sync (
  input  wire logic i_mclk,   // block clock
  input  wire logic i_nrst,   // async reset, active low
  input  wire logic i_async,  // pin level
  output logic      o_sync    // synchronised level
);
  logic [1:0] ff_q;
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      ff_q <= 2'h3;
    end else begin
      ff_q <= {ff_q[0], i_async};
    end
  end
  assign o_sync = ff_q[1];
endmodule // ajds_sync

/* ajds_timer.sv */
`timescale 1ns/1ps
module ajds_timer #(
  parameter int unsigned W = 24
) (
  input  wire logic         i_mclk,   // block clock
  input  wire logic         i_nrst,   // async reset, active low
  input  wire logic         i_clr,    // restart from zero
  input  wire logic         i_run,    // count while high
  input  wire logic [W-1:0] i_limit,  // terminal count
  output logic              o_done    // level once limit reached
);
  logic [W-1:0] cnt_q;
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt_q <= '0;
    end else if (i_clr || !i_run) begin
      cnt_q <= '0;
    end else if (cnt_q != i_limit) begin
      cnt_q <= cnt_q + W'(1);
    end
  end
  assign o_done = i_run && !i_clr && (cnt_q == i_limit);
endmodule // ajds_timer

/* tb_ajds_seq.sv */
`timescale 1ns/1ps
module tb_ajds_seq;
  localparam int INS = 50;
  localparam int REM = 30;
  localparam int DET = 5;
  logic i_mclk = 0, i_nrst = 0, lclk = 0, plug = 0, i_ovr_en = 0, i_fm_en = 0;
  logic i_det_cmd = 0, i_int_rd = 0, i_key_en = 0, i_sense_n, i_mic_sleeve, i_mic_ring_two_contact;
  logic o_alert_oe, o_alert_o, o_mic_found_n_oe, o_mic_found_n_o, o_key_act, o_sleep, o_busy;
  logic [23:0]         i_ins_cyc = 24'h0;
  logic [31:0]         seed = 32'h00001146;
  ajds_pkg::ajds_sw_t  i_ovr_sw = '0;
  ajds_pkg::ajds_sw_t  o_sw;
  ajds_pkg::ajds_acc_t o_acc;
  ajds_pkg::ajds_acc_t kind = ajds_pkg::AJDS_NONE;
  int n_fail = 0, checked = 0, cyc = 0, c;
  always #50 i_mclk = ~i_mclk;
  initial #37 forever #400 lclk = ~lclk;
  ajds_seq #(.INS_CYC(INS), .REM_CYC(REM), .DET_CYC(DET)) i_ajds_seq (.i_mclk, .i_nrst,
    .i_sense_n, .i_mic_sleeve, .i_mic_ring_two_contact, .i_ins_cyc, .i_ovr_en, .i_ovr_sw, .i_fm_en,
    .i_det_cmd, .i_int_rd, .i_key_en, .o_sw, .o_acc, .o_alert_oe, .o_alert_o,
    .o_mic_found_n_oe, .o_mic_found_n_o, .o_key_act, .o_sleep, .o_busy);
  ajds_jack_model i_ajds_jack_model (.i_lclk(lclk), .i_plug(plug), .i_kind(kind),
    .o_sense_n(i_sense_n), .o_mic_sleeve(i_mic_sleeve), .o_mic_ring_two_contact(i_mic_ring_two_contact));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [7:0] exp_sw(input int k, input logic fm);
    logic [7:0] r;
    r = (k == 2) ? 8'ha4 : (k == 3) ? 8'h58 : (k == 1) ? 8'h0c : 8'h01;
    if (k != 0) r[1] = fm;
    return r;
  endfunction
  function automatic int lim();
    return (i_ins_cyc == 24'h0) ? INS : int'(i_ins_cyc);
  endfunction
  task automatic test_done();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask
  task automatic wait_alert();
    for (c = 0; o_alert_oe !== 1'b1 && c < 400; c++) step(1);
  endtask
  task automatic rd();
    i_int_rd = 1;
    step(1);
    i_int_rd = 0;
    step(2);
    chk("alert read", 8'(o_alert_oe), 8'h0);
  endtask
  task automatic insert(input ajds_pkg::ajds_acc_t k);
    kind = k;
    plug = 1;
    step(16);
    plug = 0;
    step(24);
    plug = 1;
    wait_alert();
    chk("deb time", 8'(c >= lim() && c <= lim() + DET + 30), 8'h1);
    chk("acc", 8'(o_acc), 8'(k));
    chk("mic found", 8'(o_mic_found_n_oe), 8'(k[1]));
    chk("routes", o_sw, exp_sw(int'(k), i_fm_en));
  endtask
  task automatic remove(input logic [7:0] sw_exp);
    plug = 0;
    for (c = 0; o_acc !== ajds_pkg::AJDS_NONE && c < 40; c++) step(1);
    chk("rm sw", o_sw, sw_exp);
    chk("rm flags", 8'({o_alert_oe, o_mic_found_n_oe, o_key_act}), 8'h4);
    rd();
    step(REM + 12);
    chk("sleep", 8'(o_sleep), 8'(!i_ovr_en));
  endtask
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 8000) begin
      n_fail++;
      test_done();
    end
  end
  initial begin
    step(10);
    i_nrst = 1;
    chk("rst sw", o_sw, 8'h01);
    chk("rst sleep", 8'(o_sleep), 8'h1);
    for (int i = 1; i < 4; i++) begin
      i_ins_cyc = (i == 1) ? 24'h0 : 24'(30 + rnd() % 30);
      i_fm_en = 1'(rnd());
      insert(ajds_pkg::ajds_acc_t'(i));
      // key detection only on a headset
      i_key_en = (i > 1);
      step(4);
      chk("key", 8'(o_key_act), 8'(i_key_en));
      rd();
      if (i == 2) begin
        i_det_cmd = 1;
        step(1);
        i_det_cmd = 0;
        wait_alert();
        chk("cmd det", 8'(c < 100 && o_acc == kind), 8'h1);
      end
      remove(8'h01);
      i_key_en = 0;
    end
    i_ins_cyc = 24'd60;
    plug = 1;
    step(30);
    plug = 0;
    step(REM + 20);
    chk("early rm", 8'({o_acc, o_alert_oe, o_sleep}), 8'h1);
    insert(ajds_pkg::AJDS_3POLE);
    rd();
    i_ovr_sw = ajds_pkg::ajds_sw_t'(8'(rnd()));
    i_ovr_en = 1;
    step(3);
    chk("ovr sw", o_sw, i_ovr_sw);
    remove(i_ovr_sw);
    test_done();
  end
endmodule // tb_ajds_seq
